/* File: hdl/ksm_key_manager.sv */
/*
  key manager: slot selection, gated key store, status, push over apb.
  assumes ksm_if from the processor end and an apb slave on the same clock.
*/
// The implementer's own choices: the address-and-strobe port and the register addresses.
// Notes on behaviour
// - one selected slot gates key value access and header writes
// - select resets to zero, ids 1..128
// - good access to selected slot sets selected
// - wrong slot or failed select sets blocked
// - select write outside a push clears status; a failed one sets blocked
// - blank slot: all ones, no dest, unrestricted
// - software stores: select, dest, value, perm, zero
// - store blocked: unselected, used, unerased, foreign
// - long keys: more slots, dest plus 4 words
// - readable unused-dest slot should drop push
// - value readable only with state and read
// - blocked value read returns DEADDEAD
// - push task writes key to dest
// - successful push raises pushed event
// - push failures raise error event instead
// - revoked slot push raises revoked, no transfer
// - software revokes by writing state field
// - revocation leaves delivered keys untouched
// - multi-slot keys pushed slot by slot
// - software selects zero after each sequence
// - flash writes enabled only around storing and revoking
// - only secure transactions are served
// - state zero: never read nor pushed
`timescale 1ns/1ns
`include "ksm_params.svh"
module ksm_key_manager #(
  parameter int SLOTS = `KSM_SLOTS
)(
  input wire logic clock,
  input wire logic resetn,
  ksm_if.dev bus,
  output logic apb_psel,
  output logic apb_penable,
  output logic apb_pwrite,
  output logic [31:0] apb_paddr,
  output logic [31:0] apb_pwdata,
  input wire logic apb_pready,
  input wire logic apb_pslverr
);
  // ============================================================
  // storage: reset erases, emulating a blank key area
  logic [31:0] key_mem [SLOTS*4];
  logic [31:0] dest_mem [SLOTS];
  logic [31:0] perm_mem [SLOTS];
  logic [7:0] sel_r;
  logic st_sel_r;
  logic st_blk_r;
  logic ev_pushed_r;
  logic ev_revoked_r;
  logic ev_error_r;
  logic [31:0] rdata_r;
  ksm_pkg::ksm_push_e pst_r;
  logic [1:0] pword_r;
  logic [6:0] pslot_r;
  logic [31:0] pdest_r;

  function automatic logic slot_hit(input logic [7:0] sel,
                                    input logic [6:0] idx);
    slot_hit = (sel != 8'h00) && (idx == 7'(sel - 8'h01));
  endfunction : slot_hit

  // ============================================================
  // decode
  logic acc;
  logic wr;
  logic rd;
  logic is_hdr;
  logic is_val;
  logic [6:0] h_idx;
  logic [6:0] v_idx;
  logic [8:0] v_pos;
  logic [6:0] s_idx;
  logic [31:0] s_perm;
  logic s_empty;
  logic busy;
  logic sel_wr;
  logic sel_bad;
  logic val_wr_ok;
  logic dest_wr_ok;
  logic perm_wr_ok;
  logic val_rd_ok;
  logic set_sel;
  logic set_blk;
  logic trig;
  logic ev_ok;
  logic ev_rev;
  logic ev_err;
  logic [31:0] rd_val;

  assign acc = bus.wr | bus.rd;
  assign wr = bus.wr & bus.secure;
  assign rd = bus.rd & bus.secure;
  assign is_hdr = bus.addr[13:10] == 4'(`KSM_HDR_BASE >> 10);
  assign is_val = bus.addr[13:11] == 3'(`KSM_VAL_BASE >> 11);
  assign h_idx = bus.addr[9:3];
  assign v_idx = bus.addr[10:4];
  assign v_pos = bus.addr[10:2];
  assign s_idx = 7'(sel_r - 8'h01);
  assign s_perm = perm_mem[s_idx];
  assign s_empty = s_perm == `KSM_ERASED;
  assign busy = pst_r != ksm_pkg::KSM_P_IDLE;
  // select changes are ignored while a push runs, status included
  assign sel_wr = wr && bus.addr == `KSM_SELECT && !busy;
  assign sel_bad = sel_wr && (bus.wdata > 32'(SLOTS));
  // store needs a selected blank slot, an erased word, and flash enabled
  assign val_wr_ok = wr && is_val && slot_hit(sel_r, v_idx) && s_empty
    && key_mem[v_pos] == `KSM_ERASED && bus.flash_wen;
  assign dest_wr_ok = wr && is_hdr && !bus.addr[2]
    && slot_hit(sel_r, h_idx) && s_empty
    && dest_mem[h_idx] == `KSM_ERASED && bus.flash_wen;
  // a used slot still takes a write that only clears its state bit
  assign perm_wr_ok = wr && is_hdr && bus.addr[2]
    && slot_hit(sel_r, h_idx) && bus.flash_wen
    && (s_empty || (bus.wdata | (32'h1 << `KSM_PERM_STATE))
        == `KSM_ERASED);
  assign val_rd_ok = rd && is_val && slot_hit(sel_r, v_idx)
    && s_perm[`KSM_PERM_STATE] && s_perm[`KSM_PERM_READ];
  assign set_sel = val_rd_ok | val_wr_ok | dest_wr_ok | perm_wr_ok;
  assign set_blk = (acc && !bus.secure) || sel_bad
    || (rd && is_val && !val_rd_ok)
    || (wr && is_val && !val_wr_ok)
    || (wr && is_hdr && !dest_wr_ok && !perm_wr_ok);
  assign trig = wr && bus.addr == `KSM_TASK_PUSH && bus.wdata[0] && !busy;

  // ============================================================
  // push outcome decisions
  always_comb
  begin
    ev_ok = 1'b0;
    ev_rev = 1'b0;
    ev_err = 1'b0;
    if (trig)
    begin
      if (sel_r == 8'h00)
        ev_err = 1'b1;
      else if (!s_perm[`KSM_PERM_STATE])
        ev_rev = 1'b1;
      else if (s_empty || !s_perm[`KSM_PERM_PUSH])
        ev_err = 1'b1;
      else if (dest_mem[s_idx] == `KSM_ERASED)
        ev_err = 1'b1;
    end
    if (pst_r == ksm_pkg::KSM_P_ACCESS && apb_pready)
    begin
      ev_err = apb_pslverr;
      ev_ok = !apb_pslverr && pword_r == 2'h3;
    end
  end

  // ============================================================
  // flash emulation
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      for (int i = 0; i < SLOTS * 4; i++)
        key_mem[i] <= `KSM_ERASED;
      for (int i = 0; i < SLOTS; i++)
      begin
        dest_mem[i] <= `KSM_ERASED;
        perm_mem[i] <= `KSM_ERASED;
      end
    end
    else
    begin
      if (val_wr_ok)
        key_mem[v_pos] <= bus.wdata;
      if (dest_wr_ok)
        dest_mem[h_idx] <= bus.wdata;
      if (perm_wr_ok)
        perm_mem[h_idx] <= perm_mem[h_idx] & bus.wdata;
    end
  end

  // ============================================================
  // selection and status
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      sel_r <= 8'h00;
    else if (sel_wr)
      sel_r <= sel_bad ? 8'h00 : bus.wdata[7:0];
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_sel_r <= 1'b0;
      st_blk_r <= 1'b0;
    end
    else if (sel_wr)
    begin
      st_sel_r <= 1'b0;
      st_blk_r <= set_blk;
    end
    else
    begin
      if (set_sel)
        st_sel_r <= 1'b1;
      if (set_blk)
        st_blk_r <= 1'b1;
    end
  end

  // ============================================================
  // events: hardware set wins over a software clear
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      ev_pushed_r <= 1'b0;
      ev_revoked_r <= 1'b0;
      ev_error_r <= 1'b0;
    end
    else
    begin
      if (ev_ok)
        ev_pushed_r <= 1'b1;
      else if (wr && bus.addr == `KSM_EVT_PUSHED)
        ev_pushed_r <= bus.wdata[0];
      if (ev_rev)
        ev_revoked_r <= 1'b1;
      else if (wr && bus.addr == `KSM_EVT_REVOKED)
        ev_revoked_r <= bus.wdata[0];
      if (ev_err)
        ev_error_r <= 1'b1;
      else if (wr && bus.addr == `KSM_EVT_ERROR)
        ev_error_r <= bus.wdata[0];
    end
  end

  // ============================================================
  // push over apb, four words at dest, dest+4, dest+8, dest+12
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      pst_r <= ksm_pkg::KSM_P_IDLE;
      pword_r <= 2'h0;
      pslot_r <= 7'h00;
      pdest_r <= 32'h00000000;
      apb_psel <= 1'b0;
      apb_penable <= 1'b0;
      apb_pwrite <= 1'b0;
      apb_paddr <= 32'h00000000;
      apb_pwdata <= 32'h00000000;
    end
    else
    begin
      case (pst_r)
        ksm_pkg::KSM_P_IDLE:
        begin
          if (trig && !ev_err && !ev_rev)
          begin
            pst_r <= ksm_pkg::KSM_P_SETUP;
            pword_r <= 2'h0;
            pslot_r <= s_idx;
            pdest_r <= dest_mem[s_idx];
            apb_psel <= 1'b1;
            apb_pwrite <= 1'b1;
            apb_paddr <= dest_mem[s_idx];
            apb_pwdata <= key_mem[{s_idx, 2'h0}];
          end
        end
        ksm_pkg::KSM_P_SETUP:
        begin
          pst_r <= ksm_pkg::KSM_P_ACCESS;
          apb_penable <= 1'b1;
        end
        ksm_pkg::KSM_P_ACCESS:
        begin
          if (apb_pready)
          begin
            apb_penable <= 1'b0;
            if (apb_pslverr || pword_r == 2'h3)
            begin
              pst_r <= ksm_pkg::KSM_P_IDLE;
              apb_psel <= 1'b0;
              apb_pwrite <= 1'b0;
            end
            else
            begin
              pst_r <= ksm_pkg::KSM_P_SETUP;
              pword_r <= pword_r + 2'h1;
              apb_paddr <= pdest_r + {28'h0000000, pword_r + 2'h1, 2'h0};
              apb_pwdata <= key_mem[{pslot_r, pword_r + 2'h1}];
            end
          end
        end
        default:
          pst_r <= ksm_pkg::KSM_P_IDLE;
      endcase
    end
  end

  // ============================================================
  // read data, one cycle after the strobe; unmapped secure reads give zero
  always_comb
  begin
    rd_val = 32'h00000000;
    if (!bus.secure)
      rd_val = `KSM_DEAD;
    else if (bus.addr == `KSM_EVT_PUSHED)
      rd_val = {31'h00000000, ev_pushed_r};
    else if (bus.addr == `KSM_EVT_REVOKED)
      rd_val = {31'h00000000, ev_revoked_r};
    else if (bus.addr == `KSM_EVT_ERROR)
      rd_val = {31'h00000000, ev_error_r};
    else if (bus.addr == `KSM_STATUS)
      rd_val = {30'h00000000, st_blk_r, st_sel_r};
    else if (bus.addr == `KSM_SELECT)
      rd_val = {24'h000000, sel_r};
    else if (is_hdr)
      rd_val = bus.addr[2] ? perm_mem[h_idx] : dest_mem[h_idx];
    else if (is_val)
      rd_val = val_rd_ok ? key_mem[v_pos] : `KSM_DEAD;
  end

  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      rdata_r <= 32'h00000000;
    else if (bus.rd)
      rdata_r <= rd_val;
  end
  assign bus.rdata = rdata_r;
endmodule : ksm_key_manager

/* File: shared/ksm_params.svh */
/*
  constants of the key slot manager: bus offsets, field positions, values.
  assumes inclusion by bare name from both ends, the checker and the bench.
*/
`ifndef KSM_PARAMS_SVH
`define KSM_PARAMS_SVH
// ============================================================
// key manager space, byte offsets on the 14-bit bus
`define KSM_TASK_PUSH 14'h0000
`define KSM_EVT_PUSHED 14'h0100
`define KSM_EVT_REVOKED 14'h0104
`define KSM_EVT_ERROR 14'h0108
`define KSM_STATUS 14'h040C
`define KSM_SELECT 14'h0500
`define KSM_HDR_BASE 14'h1000
`define KSM_VAL_BASE 14'h2000
// ============================================================
// slot layout and values
`define KSM_SLOTS 128
`define KSM_PERM_WRITE 0
`define KSM_PERM_READ 1
`define KSM_PERM_PUSH 2
`define KSM_PERM_STATE 16
`define KSM_STAT_SEL 0
`define KSM_STAT_BLK 1
`define KSM_ERASED 32'hFFFFFFFF
`define KSM_DEAD 32'hDEADDEAD
`define KSM_KEY_STRIDE 32'h00000010
// ============================================================
// host register offsets on the software port
`define KSM_H_CTRL 6'h00
`define KSM_H_SLOT 6'h04
`define KSM_H_DEST 6'h08
`define KSM_H_PERM 6'h0C
`define KSM_H_KEY 6'h10
`define KSM_H_RESULT 6'h20
`define KSM_H_GO 4
`endif

/* File: shared/ksm_pkg.sv */
/*
  types shared by both ends of the key slot manager.
  assumes nothing beyond a SystemVerilog compiler.
*/
package ksm_pkg;
  typedef enum logic [1:0]
  {
    KSM_P_IDLE = 2'b00,
    KSM_P_SETUP = 2'b01,
    KSM_P_ACCESS = 2'b10
  } ksm_push_e;
  typedef enum logic [1:0]
  {
    KSM_H_IDLE = 2'b00,
    KSM_H_ISSUE = 2'b01,
    KSM_H_STROBE = 2'b10,
    KSM_H_RESULT = 2'b11
  } ksm_hst_e;
  typedef enum logic [1:0]
  {
    KSM_OP_STORE = 2'b00,
    KSM_OP_READ = 2'b01,
    KSM_OP_PUSH = 2'b10,
    KSM_OP_REVOKE = 2'b11
  } ksm_op_e;
endpackage : ksm_pkg

/* File: shared/ksm_if.sv */
/*
  link between the secure processor end and the key manager.
  assumes both ends on one clock; read data stand one cycle after rd.
*/
`timescale 1ns/1ns
interface ksm_if;
  logic wr;
  logic rd;
  logic secure;
  logic flash_wen;
  logic [13:0] addr;
  logic [31:0] wdata;
  logic [31:0] rdata;
  modport dev (input wr, rd, secure, flash_wen, addr, wdata, output rdata);
  modport host (output wr, rd, secure, flash_wen, addr, wdata, input rdata);
endinterface : ksm_if

/* File: hdl/ksm_host.sv */
/*
  secure processor end: runs store, read, push and revoke sequences.
  assumes software on the plain port and the key manager on ksm_if.
*/
`timescale 1ns/1ns
`include "ksm_params.svh"
module ksm_host (
  input wire logic clock,
  input wire logic resetn,
  ksm_if.host bus,
  input wire logic [5:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata
);
  ksm_pkg::ksm_hst_e st_r;
  ksm_pkg::ksm_op_e op_r;
  logic [3:0] step_r;
  logic [7:0] id_r;
  logic [7:0] cnt_r;
  logic [31:0] dest_r;
  logic [31:0] perm_r;
  logic [31:0] key_r [4];
  logic [3:0] res_r;
  logic wr_r;
  logic rd_r;
  logic fwen_r;
  logic [13:0] addr_r;
  logic [31:0] wdata_r;
  logic a_wr;
  logic a_rd;
  logic a_last;
  logic [13:0] a_addr;
  logic [31:0] a_data;
  logic [6:0] idx;
  logic [1:0] w;
  logic [31:0] perm_fix;

  assign idx = 7'(id_r - 8'h01);
  assign w = 2'(step_r - 4'h2);
  // unused destination: do not leave a readable key pushable
  assign perm_fix = (perm_r[`KSM_PERM_READ] && dest_r == `KSM_ERASED)
    ? perm_r & ~(32'h1 << `KSM_PERM_PUSH) : perm_r;

  // ============================================================
  // sequence steps, every one ends with select zero
  always_comb
  begin
    a_wr = 1'b1;
    a_rd = 1'b0;
    a_last = 1'b0;
    a_addr = `KSM_SELECT;
    a_data = {24'h000000, id_r};
    case (op_r)
      ksm_pkg::KSM_OP_STORE:
        if (step_r == 4'h1)
        begin
          a_addr = `KSM_HDR_BASE + {4'h0, idx, 3'h0};
          a_data = dest_r;
        end
        else if (step_r >= 4'h2 && step_r <= 4'h5)
        begin
          a_addr = `KSM_VAL_BASE + {3'h0, idx, w, 2'h0};
          a_data = key_r[w];
        end
        else if (step_r == 4'h6)
        begin
          a_addr = `KSM_HDR_BASE + {4'h0, idx, 3'h4};
          a_data = perm_fix;
        end
        else if (step_r != 4'h0)
        begin
          a_data = 32'h00000000;
          a_last = 1'b1;
        end
      ksm_pkg::KSM_OP_READ:
        if (step_r >= 4'h1 && step_r <= 4'h4)
        begin
          a_wr = 1'b0;
          a_rd = 1'b1;
          a_addr = `KSM_VAL_BASE + {3'h0, idx, 2'(step_r - 4'h1), 2'h0};
        end
        else if (step_r != 4'h0)
        begin
          a_data = 32'h00000000;
          a_last = 1'b1;
        end
      ksm_pkg::KSM_OP_PUSH:
        if (step_r == 4'h1)
        begin
          a_addr = `KSM_TASK_PUSH;
          a_data = 32'h00000001;
        end
        else if (step_r >= 4'h2 && step_r <= 4'h7)
        begin
          a_wr = step_r >= 4'h5;
          a_rd = step_r < 4'h5;
          a_data = 32'h00000000;
          a_addr = step_r == 4'h2 || step_r == 4'h5 ? `KSM_EVT_PUSHED
            : step_r == 4'h3 || step_r == 4'h6 ? `KSM_EVT_REVOKED
            : `KSM_EVT_ERROR;
        end
        else if (step_r != 4'h0)
        begin
          a_data = 32'h00000000;
          a_last = 1'b1;
        end
      default:
        if (step_r == 4'h1)
        begin
          a_addr = `KSM_HDR_BASE + {4'h0, idx, 3'h4};
          a_data = ~(32'h1 << `KSM_PERM_STATE);
        end
        else if (step_r != 4'h0)
        begin
          a_data = 32'h00000000;
          a_last = 1'b1;
        end
    endcase
  end

  // ============================================================
  // sequencer; revocation never touches the apb peripheral
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
    begin
      st_r <= ksm_pkg::KSM_H_IDLE;
      op_r <= ksm_pkg::KSM_OP_STORE;
      step_r <= 4'h0;
      id_r <= 8'h00;
      cnt_r <= 8'h00;
      dest_r <= `KSM_ERASED;
      perm_r <= `KSM_ERASED;
      key_r <= '{default: `KSM_ERASED};
      res_r <= 4'h0;
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      fwen_r <= 1'b0;
      addr_r <= 14'h0000;
      wdata_r <= 32'h00000000;
    end
    else
    begin
      wr_r <= 1'b0;
      rd_r <= 1'b0;
      case (st_r)
        ksm_pkg::KSM_H_IDLE:
        begin
          if (sw_wr && sw_addr == `KSM_H_CTRL && sw_wdata[`KSM_H_GO])
          begin
            op_r <= ksm_pkg::ksm_op_e'(sw_wdata[1:0]);
            step_r <= 4'h0;
            res_r <= 4'h0;
            st_r <= ksm_pkg::KSM_H_ISSUE;
            // flash writes open only for store and revoke
            fwen_r <= (sw_wdata[1:0] == 2'h0)
              || (sw_wdata[1:0] == 2'h3);
          end
          else if (sw_wr && sw_addr == `KSM_H_SLOT)
          begin
            id_r <= sw_wdata[7:0];
            cnt_r <= sw_wdata[15:8];
          end
          else if (sw_wr && sw_addr == `KSM_H_DEST)
            dest_r <= sw_wdata;
          else if (sw_wr && sw_addr == `KSM_H_PERM)
            perm_r <= sw_wdata;
          else if (sw_wr && sw_addr[5:4] == 2'h1)
            key_r[sw_addr[3:2]] <= sw_wdata;
        end
        ksm_pkg::KSM_H_ISSUE:
        begin
          wr_r <= a_wr;
          rd_r <= a_rd;
          addr_r <= a_addr;
          wdata_r <= a_data;
          st_r <= ksm_pkg::KSM_H_STROBE;
        end
        ksm_pkg::KSM_H_STROBE:
          st_r <= ksm_pkg::KSM_H_RESULT;
        default:
        begin
          st_r <= ksm_pkg::KSM_H_ISSUE;
          step_r <= step_r + 4'h1;
          if (op_r == ksm_pkg::KSM_OP_READ && rd_r == 1'b0 && a_rd)
          begin
            key_r[2'(step_r - 4'h1)] <= bus.rdata;
            if (bus.rdata == `KSM_DEAD)
              res_r[3] <= 1'b1;
          end
          if (op_r == ksm_pkg::KSM_OP_PUSH && a_rd)
            res_r[2'(step_r - 4'h2)] <= res_r[2'(step_r - 4'h2)]
              | bus.rdata[0];
          // poll the three events until the push has ended
          if (op_r == ksm_pkg::KSM_OP_PUSH && step_r == 4'h4
              && !(res_r[0] | res_r[1] | bus.rdata[0]))
            step_r <= 4'h2;
          if (a_last)
          begin
            step_r <= 4'h0;
            id_r <= id_r + 8'h01;
            if (op_r == ksm_pkg::KSM_OP_STORE)
              dest_r <= dest_r + `KSM_KEY_STRIDE;
            if (op_r == ksm_pkg::KSM_OP_PUSH && cnt_r > 8'h01)
              cnt_r <= cnt_r - 8'h01;
            else
            begin
              st_r <= ksm_pkg::KSM_H_IDLE;
              fwen_r <= 1'b0;
            end
          end
        end
      endcase
    end
  end

  // ============================================================
  // software read port
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      sw_rdata <= 32'h00000000;
    else if (sw_rd)
    begin
      if (sw_addr == `KSM_H_RESULT)
        sw_rdata <= {27'h0000000, res_r, st_r != ksm_pkg::KSM_H_IDLE};
      else if (sw_addr == `KSM_H_SLOT)
        sw_rdata <= {16'h0000, cnt_r, id_r};
      else if (sw_addr == `KSM_H_DEST)
        sw_rdata <= dest_r;
      else if (sw_addr == `KSM_H_PERM)
        sw_rdata <= perm_r;
      else if (sw_addr[5:4] == 2'h1)
        sw_rdata <= key_r[sw_addr[3:2]];
      else
        sw_rdata <= 32'h00000000;
    end
  end

  assign bus.wr = wr_r;
  assign bus.rd = rd_r;
  assign bus.secure = 1'b1;
  assign bus.flash_wen = fwen_r;
  assign bus.addr = addr_r;
  assign bus.wdata = wdata_r;
endmodule : ksm_host

/* File: dv/ksm_sva.sv */
/*
  checker for the key slot manager link and its push bus.
  assumes one clock, active-low reset, ksm_if and apb signals as inputs.
*/
`timescale 1ns/1ns
`include "ksm_params.svh"
module ksm_sva (
  input wire logic clock,
  input wire logic resetn,
  input wire logic wr,
  input wire logic rd,
  input wire logic flash_wen,
  input wire logic [13:0] addr,
  input wire logic [31:0] wdata,
  input wire logic [31:0] rdata,
  input wire logic apb_psel,
  input wire logic apb_penable,
  input wire logic apb_pwrite,
  input wire logic [31:0] apb_paddr,
  input wire logic apb_pready
);
  // ============================================================
  // helper: id last written to the select register
  logic [7:0] sel_r;
  always_ff @(posedge clock or negedge resetn)
  begin
    if (!resetn)
      sel_r <= 8'h00;
    else if (wr && addr == `KSM_SELECT)
      sel_r <= wdata[7:0];
  end
  // ============================================================
  // properties
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!resetn);
  sequence s_acc;
    apb_psel && apb_penable;
  endsequence
  property p_strobe; !(wr && rd); endproperty
  a_strobe: assert property (p_strobe)
    else $error("wr and rd together");
  property p_dead;
    rd && addr[13:12] == 2'h2 && sel_r == 8'h00 |=> rdata == `KSM_DEAD;
  endproperty
  a_dead: assert property (p_dead)
    else $error("unselected value read not blocked");
  property p_flash; wr && addr >= `KSM_HDR_BASE |-> flash_wen; endproperty
  a_flash: assert property (p_flash)
    else $error("key store write without flash enable");
  property p_setup; $rose(apb_psel) |=> s_acc; endproperty
  a_setup: assert property (p_setup)
    else $error("no access phase after setup");
  property p_hold;
    s_acc and !apb_pready |=> apb_penable && $stable(apb_paddr);
  endproperty
  a_hold: assert property (p_hold)
    else $error("push word dropped while stalled");
  property p_step; s_acc and apb_pready |=> !apb_penable; endproperty
  a_step: assert property (p_step)
    else $error("access phase not closed");
  property p_next;
    $fell(apb_penable) && apb_psel |-> apb_paddr == $past(apb_paddr) + 32'h4;
  endproperty
  a_next: assert property (p_next)
    else $error("push address not stepped by four");
  property p_write; apb_psel |-> apb_pwrite; endproperty
  a_write: assert property (p_write)
    else $error("push transfer is not a write");
endmodule : ksm_sva

/* File: dv/key_slot_manager_tb.sv */
/*
  bench: software port drives store, read, push, revoke; apb slave stalls.
  assumes the host and key manager joined by ksm_if on one clock.
*/
`timescale 1ns/1ns
`include "ksm_params.svh"
module key_slot_manager_tb;
  logic clock = 1'b0;
  logic resetn = 1'b0;
  logic [5:0] sw_addr = 6'h00;
  logic [31:0] sw_wdata = 32'h00000000;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic [31:0] sw_rdata;
  logic apb_psel, apb_penable, apb_pwrite;
  logic [31:0] apb_paddr, apb_pwdata, r, d;
  logic apb_pready = 1'b0;
  logic apb_pslverr = 1'b0;
  logic [31:0] key [4] = '{32'h01234567, 32'h89ABCDEF, 32'hC0FFEE00,
                           32'h5A5AA5A5};
  logic [31:0] dest = 32'h40001000;
  int n_mismatch = 0;
  int tests_run = 0;
  int cyc = 0;
  int nxfer = 0;
  int w = 0;
  always #20 clock = ~clock;
  ksm_if bus_if ();
  ksm_key_manager ksm_key_manager_inst (.clock(clock), .resetn(resetn),
    .bus(bus_if), .apb_psel(apb_psel), .apb_penable(apb_penable),
    .apb_pwrite(apb_pwrite), .apb_paddr(apb_paddr),
    .apb_pwdata(apb_pwdata), .apb_pready(apb_pready),
    .apb_pslverr(apb_pslverr));
  ksm_host ksm_host_inst (.clock(clock), .resetn(resetn), .bus(bus_if),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd),
    .sw_rdata(sw_rdata));
  ksm_sva ksm_sva_inst (.clock(clock), .resetn(resetn), .wr(bus_if.wr),
    .rd(bus_if.rd), .flash_wen(bus_if.flash_wen), .addr(bus_if.addr),
    .wdata(bus_if.wdata), .rdata(bus_if.rdata), .apb_psel(apb_psel),
    .apb_penable(apb_penable), .apb_pwrite(apb_pwrite),
    .apb_paddr(apb_paddr), .apb_pready(apb_pready));
  // ============================================================
  // tasks
  task chk(input logic [31:0] g, input logic [31:0] e);
    tests_run++;
    if (g !== e)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task close_out;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : close_out
  task swr(input logic [5:0] a, input logic [31:0] v);
    @(posedge clock);
    sw_addr <= a;
    sw_wdata <= v;
    sw_wr <= 1'b1;
    @(posedge clock);
    sw_wr <= 1'b0;
  endtask : swr
  task swrd(input logic [5:0] a, output logic [31:0] v);
    @(posedge clock);
    sw_addr <= a;
    sw_rd <= 1'b1;
    @(posedge clock);
    sw_rd <= 1'b0;
    #1 v = sw_rdata;
  endtask : swrd
  // go on one slot, then poll busy under a bound
  task run(input logic [7:0] id, input ksm_pkg::ksm_op_e op);
    int i;
    swr(`KSM_H_SLOT, {16'h0000, 8'h01, id});
    swr(`KSM_H_CTRL, {27'h0000000, 3'h4, op});
    for (i = 0; i < 300; i++)
    begin
      swrd(`KSM_H_RESULT, r);
      if (r[0] === 1'b0)
        break;
    end
    chk(r & 32'h00000001, 32'h00000000);
  endtask : run
  task store(input logic [7:0] id, input logic [31:0] perm);
    int i;
    swr(`KSM_H_DEST, dest);
    for (i = 0; i < 4; i++)
      swr(`KSM_H_KEY + 6'(4 * i), key[i]);
    swr(`KSM_H_PERM, perm);
    run(id, ksm_pkg::KSM_OP_STORE);
  endtask : store
  // ============================================================
  // push target: stalls on alternate cycles, checks every word
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    apb_pready <= apb_psel && apb_penable && !apb_pready && cyc[0];
    if (apb_psel && apb_penable && apb_pready)
    begin
      chk(apb_paddr, dest + 32'(4 * w));
      chk(apb_pwdata, key[w]);
      w = (w + 1) % 4;
      nxfer++;
    end
    if (cyc == 60000)
    begin
      n_mismatch++;
      close_out();
    end
  end
  // ============================================================
  // sequence of tests
  initial
  begin
    repeat (12) @(posedge clock);
    resetn <= 1'b1;
    store(8'h01, 32'hFFFFFFFE);
    // wiped first, so a read that never ran cannot pass
    for (int i = 0; i < 4; i++)
      swr(`KSM_H_KEY + 6'(4 * i), 32'h00000000);
    run(8'h01, ksm_pkg::KSM_OP_READ);
    chk(r & 32'h00000010, 32'h00000000);
    for (int i = 0; i < 4; i++)
    begin
      swrd(`KSM_H_KEY + 6'(4 * i), d);
      chk(d, key[i]);
    end
    $display("test store and read done");
    run(8'h01, ksm_pkg::KSM_OP_PUSH);
    chk(r & 32'h00000002, 32'h00000002);
    chk(32'(nxfer), 32'h00000004);
    $display("test push done");
    run(8'h01, ksm_pkg::KSM_OP_REVOKE);
    run(8'h01, ksm_pkg::KSM_OP_PUSH);
    chk(r & 32'h00000004, 32'h00000004);
    chk(32'(nxfer), 32'h00000004);
    run(8'h01, ksm_pkg::KSM_OP_READ);
    chk(r & 32'h00000010, 32'h00000010);
    swrd(`KSM_H_KEY, d);
    chk(d, `KSM_DEAD);
    $display("test revoke done");
    store(8'h02, 32'hFFFFFFFF);
    run(8'h02, ksm_pkg::KSM_OP_PUSH);
    chk(r & 32'h00000008, 32'h00000008);
    run(8'h00, ksm_pkg::KSM_OP_READ);
    chk(r & 32'h00000010, 32'h00000010);
    $display("test default and no slot done");
    close_out();
  end
endmodule : key_slot_manager_tb
